/* File: logic/ctp_pkg.sv */
package ctp_pkg;
    localparam logic [11:0] CTP_OFF_EVEN_CTRL_A = 12'h000;
    localparam logic [11:0] CTP_OFF_ODD_CTRL_A = 12'h004;
    localparam logic [11:0] CTP_OFF_EVEN_CTRL_B = 12'h008;
    localparam logic [11:0] CTP_OFF_ODD_CTRL_B = 12'h00C;
    localparam logic [11:0] CTP_OFF_PERIOD_BASE = 12'h010;
    localparam logic [11:0] CTP_OFF_COUNT_BASE = 12'h020;
    localparam logic [11:0] CTP_OFF_IRQ_STATUS = 12'h030;
    localparam logic [11:0] CTP_OFF_IRQ_MASK = 12'h034;
    localparam int CTP_BIT_TIMER_ON = 15;
    localparam int CTP_BIT_GATE = 6;
    localparam int CTP_BIT_PRESCALE_LO = 4;
    localparam int CTP_BIT_CHAIN = 3;
    localparam int CTP_BIT_CLK_SRC = 1;
    localparam int CTP_BIT_PRIO_LO = 8;
    localparam int CTP_BIT_IRQ_EN = 12;
    localparam logic [15:0] CTP_CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTP_CTRL_WMASK = 16'h977A;
    localparam logic [15:0] CTP_PERIOD_RESET = 16'hFFFF;
    localparam logic [3:0] CTP_STATUS_RESET = 4'h0;
    localparam int CTP_NUM_TIMERS = 4;
    localparam int CTP_NUM_PAIRS = 2;
endpackage : ctp_pkg

/* File: logic/ctp_tick_if.sv */
`timescale 1ns/1ns
interface ctp_tick_if;
    logic extSync;
    logic [1:0] prescaleSel;
    logic clkSourceSel;
    logic gateEnable;
    logic timerOn;
    logic tick;
    modport source(input extSync, prescaleSel, clkSourceSel, gateEnable,
        timerOn, output tick);
    modport sink(output extSync, prescaleSel, clkSourceSel, gateEnable,
        timerOn, input tick);
endinterface : ctp_tick_if

/* File: logic/ctp_prescaler.sv */
`timescale 1ns/1ns
module ctp_prescaler (
    input wire logic clk_sys,
    input wire logic rst_b,
    ctp_tick_if.source tk
);
    typedef struct packed {
        logic [7:0] div;
        logic extPrev;
        logic tick;
    } ctp_pre_state_type;
    ctp_pre_state_type state;
    ctp_pre_state_type next_state;
    logic rawEdge;
    logic [7:0] limit;

    always_comb begin
        next_state = state;
        // Gate mode counts system clocks while the gate pin is high
        if (tk.gateEnable && !tk.clkSourceSel) begin
            rawEdge = tk.extSync;
        end else if (tk.clkSourceSel) begin
            rawEdge = tk.extSync && !state.extPrev;
        end else begin
            rawEdge = 1'b1;
        end
        case (tk.prescaleSel)
            2'h0: limit = 8'h00;
            2'h1: limit = 8'h07;
            2'h2: limit = 8'h3F;
            default: limit = 8'hFF;
        endcase
        next_state.extPrev = tk.extSync;
        next_state.tick = 1'b0;
        if (!tk.timerOn) begin
            next_state.div = 8'h00;
        end else if (rawEdge) begin
            if (state.div >= limit) begin
                next_state.div = 8'h00;
                next_state.tick = 1'b1;
            end else begin
                next_state.div = state.div + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Stopping the timer drops a tick still in flight
    assign tk.tick = state.tick && tk.timerOn;
endmodule : ctp_prescaler

/* File: logic/ctp_timer_pair.sv */
`timescale 1ns/1ns
module ctp_timer_pair (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] extPins,
    input wire logic [11:0] remapInputSel,
    output logic irqOut,
    output logic [2:0] irqPrio,
    output logic adcTrigger
);
    localparam int NT = ctp_pkg::CTP_NUM_TIMERS;

    typedef struct packed {
        logic [NT-1:0][15:0] ctrl;
        logic [NT-1:0][15:0] period;
        logic [NT-1:0][15:0] count;
        logic [NT-1:0] status;
        logic [NT-1:0] mask;
        logic [7:0] ext1;
        logic [7:0] ext2;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic irq;
        logic [2:0] prio;
        logic adc;
    } ctp_state_type;

    ctp_state_type state;
    ctp_state_type next_state;
    logic [NT-1:0] tick;
    logic [NT-1:0] match;
    logic [1:0] chained;

    // Effective control word: when chained the odd timer uses the even one
    function automatic logic [15:0] ctp_eff_ctrl(
        input logic [NT-1:0][15:0] c, input int i);
        logic [15:0] r;
        r = c[i];
        if ((i % 2) == 1 && c[i-1][ctp_pkg::CTP_BIT_CHAIN]) begin
            r = c[i-1];
        end
        return r;
    endfunction : ctp_eff_ctrl

    genvar g;
    generate
        for (g = 0; g < NT; g++) begin : gen_pre
            ctp_tick_if tk();
            localparam int EV = g - (g % 2);
            logic [15:0] ec;
            logic [2:0] pinSel;
            assign ec = ctp_eff_ctrl(state.ctrl, g);
            // Chained odd timer listens to the even timer's pin
            assign pinSel = state.ctrl[EV][ctp_pkg::CTP_BIT_CHAIN] ?
                remapInputSel[3 * EV +: 3] : remapInputSel[3 * g +: 3];
            assign tk.extSync = state.ext2[pinSel];
            assign tk.prescaleSel =
                ec[ctp_pkg::CTP_BIT_PRESCALE_LO +: 2];
            assign tk.clkSourceSel = ec[ctp_pkg::CTP_BIT_CLK_SRC];
            assign tk.gateEnable = ec[ctp_pkg::CTP_BIT_GATE];
            assign tk.timerOn = ec[ctp_pkg::CTP_BIT_TIMER_ON];
            assign tick[g] = tk.tick;
            ctp_prescaler u_pre (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .tk(tk)
            );
        end
    endgenerate

    always_comb begin
        logic [31:0] c32;
        logic [31:0] p32;
        logic [3:0] idx;
        logic [15:0] wv;
        logic [NT-1:0] setEv;
        logic [NT-1:0] hit;
        int e;
        c32 = '0;
        p32 = '0;
        idx = '0;
        wv = '0;
        setEv = '0;
        hit = '0;
        e = 0;
        next_state = state;
        next_state.ext1 = extPins;
        next_state.ext2 = state.ext1;
        for (int p = 0; p < ctp_pkg::CTP_NUM_PAIRS; p++) begin
            e = 2 * p;
            chained[p] = state.ctrl[e][ctp_pkg::CTP_BIT_CHAIN];
            if (chained[p]) begin
                c32 = {state.count[e+1], state.count[e]};
                p32 = {state.period[e+1], state.period[e]};
                hit[e+1] = (c32 == p32);
                if (tick[e]) begin
                    c32 = hit[e+1] ? 32'h0000_0000 : c32 + 32'h0000_0001;
                    setEv[e+1] = hit[e+1];
                end
                next_state.count[e+1] = c32[31:16];
                next_state.count[e] = c32[15:0];
            end else begin
                for (int k = e; k < e + 2; k++) begin
                    hit[k] = (state.count[k] == state.period[k]);
                    if (tick[k]) begin
                        next_state.count[k] = hit[k] ? 16'h0000 :
                            state.count[k] + 16'h0001;
                        setEv[k] = hit[k];
                    end
                end
            end
        end
        match = setEv;
        next_state.adc = setEv[1];
        next_state.ready = psel && !penable;
        next_state.err = 1'b0;
        if (psel && !penable) begin
            idx = paddr[5:2];
            next_state.rdata = '0;
            next_state.err = (paddr[11:6] != 6'h00) || (idx > 4'hD) ||
                (paddr[1:0] != 2'h0);
            if (next_state.err) begin
                next_state.rdata = '0;
            end else if (idx < 4'h4) begin
                next_state.rdata = {16'h0000, state.ctrl[idx[1:0]]};
            end else if (idx < 4'h8) begin
                next_state.rdata = {16'h0000, state.period[idx[1:0]]};
            end else if (idx < 4'hC) begin
                next_state.rdata = {16'h0000, state.count[idx[1:0]]};
            end else if (idx == 4'hC) begin
                next_state.rdata = {28'h0, state.status};
            end else if (idx == 4'hD) begin
                next_state.rdata = {28'h0, state.mask};
            end
        end
        // Set wins over write-one-to-clear
        next_state.status = state.status | setEv;
        if (psel && penable && state.ready && pwrite && !state.err) begin
            idx = paddr[5:2];
            wv = pwdata[15:0];
            if (idx < 4'h4) begin
                next_state.ctrl[idx[1:0]] = wv & ctp_pkg::CTP_CTRL_WMASK;
            end else if (idx < 4'h8) begin
                next_state.period[idx[1:0]] = wv;
            end else if (idx < 4'hC) begin
                next_state.count[idx[1:0]] = wv;
            end else if (idx == 4'hC) begin
                next_state.status = (state.status & ~pwdata[NT-1:0]) | setEv;
            end else if (idx == 4'hD) begin
                next_state.mask = pwdata[NT-1:0];
            end
        end
        next_state.irq = 1'b0;
        next_state.prio = 3'h0;
        for (int i = 0; i < NT; i++) begin
            if (state.status[i] && state.mask[i] &&
                state.ctrl[i][ctp_pkg::CTP_BIT_IRQ_EN]) begin
                next_state.irq = 1'b1;
                if (state.ctrl[i][ctp_pkg::CTP_BIT_PRIO_LO +: 3] >
                    next_state.prio) begin
                    next_state.prio =
                        state.ctrl[i][ctp_pkg::CTP_BIT_PRIO_LO +: 3];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
            for (int i = 0; i < NT; i++) begin
                state.period[i] <= ctp_pkg::CTP_PERIOD_RESET;
            end
        end else begin
            state <= next_state;
        end
    end

    assign prdata = state.rdata;
    assign pready = state.ready;
    assign pslverr = state.err;
    assign irqOut = state.irq;
    assign irqPrio = state.prio;
    assign adcTrigger = state.adc;

    property p_chain_irq_odd;
        @(posedge clk_sys) disable iff (!rst_b)
        chained[0] |-> !match[0];
    endproperty
    a_chain_irq_odd: assert property (p_chain_irq_odd)
        else $error("even flag set while chained");

    property p_adc_from_odd;
        @(posedge clk_sys) disable iff (!rst_b)
        match[1] |=> adcTrigger;
    endproperty
    a_adc_from_odd: assert property (p_adc_from_odd)
        else $error("trigger missing after odd match");

    property p_adc_only_odd;
        @(posedge clk_sys) disable iff (!rst_b)
        adcTrigger |-> $past(match[1]);
    endproperty
    a_adc_only_odd: assert property (p_adc_only_odd)
        else $error("trigger without odd match");

    property p_sticky;
        @(posedge clk_sys) disable iff (!rst_b)
        match[0] |=> state.status[0];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag not set on match");

    property p_wrap;
        @(posedge clk_sys) disable iff (!rst_b)
        (match[2] && !chained[1] && !(psel && penable && pwrite))
            |=> state.count[2] == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("count did not wrap");

    property p_off_hold;
        @(posedge clk_sys) disable iff (!rst_b)
        (!state.ctrl[0][ctp_pkg::CTP_BIT_TIMER_ON] && !chained[0] &&
            !(psel && pwrite))
            |=> $stable(state.count[0]);
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("count moved while off");

    property p_irq_level;
        @(posedge clk_sys) disable iff (!rst_b)
        ((state.status & state.mask) == 4'h0) |=> !irqOut;
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq without unmasked flag");

    property p_ready_two;
        @(posedge clk_sys) disable iff (!rst_b)
        (psel && !penable) |=> pready;
    endproperty
    a_ready_two: assert property (p_ready_two)
        else $error("no ready in access phase");

    property p_adc_pair_b;
        @(posedge clk_sys) disable iff (!rst_b)
        (match[3] && !match[1]) |=> !adcTrigger;
    endproperty
    a_adc_pair_b: assert property (p_adc_pair_b)
        else $error("trigger from second pair");

    property p_odd_flag;
        @(posedge clk_sys) disable iff (!rst_b)
        match[1] |=> state.status[1];
    endproperty
    a_odd_flag: assert property (p_odd_flag)
        else $error("odd flag not set on match");

    property p_sticky_hold;
        @(posedge clk_sys) disable iff (!rst_b)
        (state.status[0] && !(psel && penable && pwrite)) |=> state.status[0];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("flag dropped without clear");

    property p_chain_even_clock;
        @(posedge clk_sys) disable iff (!rst_b)
        (chained[0] && !tick[0] && !(psel && penable))
            |=> ($stable(state.count[0]) && $stable(state.count[1]));
    endproperty
    a_chain_even_clock: assert property (p_chain_even_clock)
        else $error("chained count moved without even tick");

    property p_single_match;
        @(posedge clk_sys) disable iff (!rst_b)
        (!chained[0] && tick[0] && state.count[0] == state.period[0])
            |-> match[0];
    endproperty
    a_single_match: assert property (p_single_match)
        else $error("16-bit match missed");

    property p_chain_match;
        @(posedge clk_sys) disable iff (!rst_b)
        (chained[0] && tick[0] && {state.count[1], state.count[0]} ==
            {state.period[1], state.period[0]}) |-> match[1];
    endproperty
    a_chain_match: assert property (p_chain_match)
        else $error("32-bit match missed");

    sequence s_low_wrap;
        chained[0] && tick[0] && !match[1] &&
            state.count[0] == 16'hFFFF && !(psel && penable);
    endsequence

    property p_chain_carry;
        @(posedge clk_sys) disable iff (!rst_b)
        s_low_wrap |=> (state.count[0] == 16'h0000 &&
            state.count[1] == $past(state.count[1]) + 16'h0001);
    endproperty
    a_chain_carry: assert property (p_chain_carry)
        else $error("low word did not carry into high word");

    property p_irq_raise;
        @(posedge clk_sys) disable iff (!rst_b)
        (state.status[1] && state.mask[1] &&
            state.ctrl[1][ctp_pkg::CTP_BIT_IRQ_EN]) |=> irqOut;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("enabled odd flag gave no request");

    property p_off_hold_b;
        @(posedge clk_sys) disable iff (!rst_b)
        (!state.ctrl[3][ctp_pkg::CTP_BIT_TIMER_ON] && !chained[1] &&
            !(psel && pwrite)) |=> $stable(state.count[3]);
    endproperty
    a_off_hold_b: assert property (p_off_hold_b)
        else $error("odd count moved while off");

    property p_no_match_off;
        @(posedge clk_sys) disable iff (!rst_b)
        (!state.ctrl[2][ctp_pkg::CTP_BIT_TIMER_ON] && !chained[1])
            |-> !match[2];
    endproperty
    a_no_match_off: assert property (p_no_match_off)
        else $error("match while timer off");

    property p_chain_wrap;
        @(posedge clk_sys) disable iff (!rst_b)
        (match[1] && chained[0] && !(psel && penable && pwrite))
            |=> (state.count[1] == 16'h0000 && state.count[0] == 16'h0000);
    endproperty
    a_chain_wrap: assert property (p_chain_wrap)
        else $error("32-bit count did not wrap");
endmodule : ctp_timer_pair

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin mismatches++; \
$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module tb_top;
    logic clkSys = 1'b0;
    logic rstB = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [11:0] remapSel = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0] extPins = 8'h00;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic irqOut;
    logic adcTrigger;
    logic [2:0] irqPrio;
    int mismatches = 0;
    int testsRun = 0;
    int cycles = 0;
    int adcCount = 0;
    int c0;

    always #5 clkSys = ~clkSys;

    // Hang guard and trigger pulse count
    always @(negedge clkSys) begin
        cycles++;
        if (adcTrigger === 1'b1) adcCount++;
        if (cycles == 90000) begin
            mismatches++;
            conclude();
        end
    end

    ctp_timer_pair ctp_timer_pair_i (.clk_sys(clkSys), .rst_b(rstB),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extPins(extPins), .remapInputSel(remapSel),
        .irqOut(irqOut), .irqPrio(irqPrio), .adcTrigger(adcTrigger));

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clkSys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clkSys);
        penable <= 1'b1;
        @(posedge clkSys);
        while (pready !== 1'b1) begin
            @(posedge clkSys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd, e)
    endtask : rdChk

    task automatic waitIrq(input int lim);
        int n;
        n = 0;
        while (irqOut !== 1'b1 && n < lim) begin
            @(negedge clkSys);
            n++;
        end
    endtask : waitIrq

    task automatic pulse(input int p);
        @(posedge clkSys);
        extPins[p] <= 1'b1;
        repeat (4) @(posedge clkSys);
        extPins[p] <= 1'b0;
        repeat (4) @(posedge clkSys);
    endtask : pulse

    task automatic sReset;
        rdChk(12'h000, 32'h00000000);
        rdChk(12'h010, 32'h0000FFFF);
        rdChk(12'h030, 32'h00000000);
        apb(1'b1, 12'h000, 32'h00000020);
        apb(1'b1, 12'h040, 32'h00000005);
        `CHK(err, 1'b1)
        rdChk(12'h040, 32'h00000000);
        rdChk(12'h000, 32'h00000020);
        apb(1'b1, 12'h000, 32'h00000000);
    endtask : sReset

    task automatic sSingle;
        apb(1'b1, 12'h010, 32'h00000004);
        apb(1'b1, 12'h034, 32'h0000000F);
        apb(1'b1, 12'h000, 32'h00009500);
        waitIrq(200);
        `CHK(irqOut, 1'b1)
        `CHK(irqPrio, 3'h5)
        `CHK(adcCount, 0)
        rdChk(12'h030, 32'h00000001);
        apb(1'b1, 12'h034, 32'h00000000);
        repeat (2) @(negedge clkSys);
        `CHK(irqOut, 1'b0)
        apb(1'b1, 12'h000, 32'h00000000);
        apb(1'b1, 12'h030, 32'h0000000F);
        apb(1'b1, 12'h034, 32'h0000000F);
        rdChk(12'h030, 32'h00000000);
        `CHK(irqOut, 1'b0)
    endtask : sSingle

    task automatic sChain;
        apb(1'b1, 12'h020, 32'h00000000);
        apb(1'b1, 12'h014, 32'h00000001);
        apb(1'b1, 12'h010, 32'h00000000);
        // Odd timer also switched on; chained it must stay passive
        apb(1'b1, 12'h000, 32'h00000008);
        apb(1'b1, 12'h004, 32'h00009600);
        apb(1'b1, 12'h000, 32'h00008008);
        c0 = cycles;
        repeat (600) @(negedge clkSys);
        `CHK(irqOut, 1'b0)
        rdChk(12'h024, 32'h00000000);
        apb(1'b0, 12'h020, 32'h00000000);
        `CHK(rd > 32'h00000200, 1'b1)
        waitIrq(66000);
        `CHK(cycles - c0 > 65000, 1'b1)
        `CHK(irqPrio, 3'h6)
        rdChk(12'h030, 32'h00000002);
        `CHK(adcCount > 0, 1'b1)
        apb(1'b1, 12'h004, 32'h00000000);
        apb(1'b1, 12'h000, 32'h00000000);
        apb(1'b1, 12'h030, 32'h0000000F);
    endtask : sChain

    task automatic sExt;
        remapSel <= 12'h140;
        apb(1'b1, 12'h018, 32'h00000002);
        apb(1'b1, 12'h008, 32'h00008002);
        pulse(4);
        pulse(5);
        pulse(5);
        rdChk(12'h028, 32'h00000002);
        pulse(5);
        rdChk(12'h030, 32'h00000004);
        rdChk(12'h028, 32'h00000000);
        apb(1'b1, 12'h008, 32'h00000000);
        apb(1'b1, 12'h030, 32'h0000000F);
    endtask : sExt

    task automatic sPrescale;
        apb(1'b1, 12'h01C, 32'h00000001);
        apb(1'b1, 12'h00C, 32'h00008010);
        repeat (10) @(negedge clkSys);
        rdChk(12'h030, 32'h00000000);
        repeat (30) @(negedge clkSys);
        rdChk(12'h030, 32'h00000008);
    endtask : sPrescale

    task automatic conclude;
        if (mismatches == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (16) @(posedge clkSys);
        rstB <= 1'b1;
        sReset();
        sSingle();
        sChain();
        sExt();
        sPrescale();
        conclude();
    end
endmodule : tb_top
